// ==== design/rdss_pkg.sv ====
// constants, state codes and register map for the read data sync sequencer
// assumes one 20 MHz clock domain and an AXI4-Lite master with 32-bit data
package rdss_pkg;

	// register byte offsets
	localparam logic [7:0] RDSS_REG_STROBE = 8'h00;
	localparam logic [7:0] RDSS_REG_CONFIG = 8'h04;
	localparam logic [7:0] RDSS_REG_STATUS = 8'h08;

	// strobe word layout and reset value
	localparam int RDSS_STROBE_DIR_BIT = 4;
	localparam int RDSS_STROBE_W = 5;
	localparam logic [4:0] RDSS_STROBE_RST = 5'h00;

	// config layout and reset value
	localparam int RDSS_CFG_COAST_BIT = 0;
	localparam logic [0:0] RDSS_CFG_RST = 1'h0;

	// status layout
	localparam int RDSS_ST_STATE_LSB = 0;
	localparam int RDSS_ST_FOUND_BIT = 3;
	localparam int RDSS_ST_SRC_BIT = 4;
	localparam int RDSS_ST_STROBE_LSB = 5;
	localparam int RDSS_ST_SUBR_LSB = 10;

	// sequencing counts
	localparam logic [1:0] RDSS_ZPS_VCO_CYCLES = 2'h2;
	localparam logic [1:0] RDSS_ZPS_DATA_PULSES = 2'h2;
	localparam logic [5:0] RDSS_PRE_CNT_SHORT = 6'h20;
	localparam logic [5:0] RDSS_PRE_CNT_LONG = 6'h10;
	localparam logic [1:0] RDSS_PRE_TYPE_4T = 2'h3;
	localparam logic [3:0] RDSS_IND_MIN_CYC = 4'h2;

	// axi responses
	localparam logic [1:0] RDSS_RESP_OKAY = 2'h0;
	localparam logic [1:0] RDSS_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		SEQ_IDLE = 3'b000,
		SEQ_ZPS_WAIT = 3'b001,
		SEQ_PAUSE = 3'b010,
		SEQ_FREQ = 3'b011,
		SEQ_PHASE = 3'b100
	} rdss_seq_t;

endpackage : rdss_pkg

// ==== design/rdss_ctrl_shift.sv ====
// three-wire serial load of the window strobe word
// assumes shift clock, data and enable are synchronous samples on aclk
`timescale 1ns/100ps
module rdss_ctrl_shift
	import rdss_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// serial pins
	input wire logic shift_clock,
	input wire logic shift_data,
	input wire logic shift_enable,
	// loaded word
	output logic [4:0] word_q,
	output logic apply_q
);
	logic clk_prev_q;
	logic en_prev_q;
	logic [4:0] shift_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			clk_prev_q <= 1'b0;
			en_prev_q <= 1'b1;
		end
		else
		begin
			clk_prev_q <= shift_clock;
			en_prev_q <= shift_enable;
		end
	end

	// first bit shifted ends up as the direction bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			shift_q <= RDSS_STROBE_RST;
		else if (!shift_enable && shift_clock && !clk_prev_q)
			shift_q <= {shift_q[3:0], shift_data};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			word_q <= RDSS_STROBE_RST;
			apply_q <= 1'b0;
		end
		else
		begin
			apply_q <= shift_enable && !en_prev_q;
			if (shift_enable && !en_prev_q)
				word_q <= shift_q;
		end
	end

	chk_shift_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		shift_enable |=> $stable(shift_q))
		else $error("shift register moved while enable high");

endmodule : rdss_ctrl_shift

// ==== design/rdss_phase_cmp.sv ====
// phase comparator indicator pulses for data against the oscillator
// assumes vco level and pulse strobes come from the top's sample flops
`timescale 1ns/100ps
module rdss_phase_cmp
	import rdss_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// phase inputs
	input wire logic vco_level,
	input wire logic vco_fall,
	input wire logic data_rise,
	input wire logic clear,
	// indicators
	output logic raise_q,
	output logic lower_q
);
	logic [3:0] since_fall_q;
	logic raise_wait_q;
	logic [3:0] raise_cnt_q;
	logic [3:0] lower_cnt_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || vco_fall)
			since_fall_q <= 4'h0;
		else if (since_fall_q != 4'hf)
			since_fall_q <= since_fall_q + 4'h1;
	end

	// early data: pulse runs to window centre plus the minimum width
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
		begin
			raise_wait_q <= 1'b0;
			raise_cnt_q <= 4'h0;
		end
		else if (data_rise && vco_level)
		begin
			raise_wait_q <= 1'b1;
			raise_cnt_q <= 4'h0;
		end
		else if (raise_wait_q && vco_fall)
		begin
			raise_wait_q <= 1'b0;
			raise_cnt_q <= RDSS_IND_MIN_CYC;
		end
		else if (raise_cnt_q != 4'h0)
			raise_cnt_q <= raise_cnt_q - 4'h1;
	end

	// late data: width grows with the time since window centre
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
			lower_cnt_q <= 4'h0;
		else if (data_rise && !vco_level)
			lower_cnt_q <= (since_fall_q > 4'hd) ? 4'hf : since_fall_q + RDSS_IND_MIN_CYC;
		else if (lower_cnt_q != 4'h0)
			lower_cnt_q <= lower_cnt_q - 4'h1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			raise_q <= 1'b0;
			lower_q <= 1'b0;
		end
		else
		begin
			raise_q <= raise_wait_q || (raise_cnt_q != 4'h0);
			lower_q <= lower_cnt_q != 4'h0;
		end
	end

	chk_lower_min_width: assert property (@(posedge aclk) disable iff (!aresetn || clear)
		(data_rise && !vco_level) |=> ##1 lower_q [*2])
		else $error("lower indicator narrower than minimum");

endmodule : rdss_phase_cmp

// ==== design/rdss_top.sv ====
// read data sync sequencer: lock sequencing, clock mux, indicators, strobe
// assumes all pins are synchronous samples on aclk except read gate and freq_acq_n
`timescale 1ns/100ps
module rdss_top
	import rdss_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// loop control pins
	input wire logic read_gate,
	input wire logic freq_acq_n,
	input wire logic freerun_hold_n,
	input wire logic boost_gain_off,
	input wire logic [1:0] preamble_type_sel,
	input wire logic [2:0] rate_range_sel,
	// clock and data samples
	input wire logic ref_clk,
	input wire logic vco_clk,
	input wire logic raw_read_pulses,
	// serial control port
	input wire logic ctrl_shift_clock,
	input wire logic ctrl_shift_data,
	input wire logic ctrl_shift_enable,
	// recovered outputs
	output logic recovered_clock_out,
	output logic resynced_data,
	output logic preamble_found,
	output logic phase_raise_ind,
	output logic phase_lower_ind,
	// loop steering
	output logic vco_run,
	output logic zero_phase_restart,
	output logic freq_acq_active,
	output logic [1:0] freq_target_sel,
	output logic window_gate_en,
	output logic pump_enable,
	output logic comparator_clear,
	output logic boost_resistor_en,
	output logic [2:0] vco_subrange,
	output logic [4:0] strobe_word,
	output logic signed [4:0] strobe_steps
);
	rdss_seq_t state_q, state_d;
	logic gate_m_q, gate_s_q, facq_m_q, facq_s_q;
	logic vco_q, vco_prev_q, ref_q, data_prev_q;
	logic vco_rise, vco_fall, data_rise;
	logic [1:0] zps_cnt_q, zps_cnt_d;
	logic [5:0] pre_cnt_q;
	logic [5:0] pre_target;
	logic src_vco_q, dead_q, want_vco, cur_src, new_src;
	logic data_pend_q;
	logic [4:0] strobe_q;
	logic [0:0] cfg_q;
	logic [4:0] ser_word;
	logic ser_apply;
	logic aw_got_q, w_got_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic coast;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// read gate and freq_acq_n may move at any time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gate_m_q <= 1'b0;
			gate_s_q <= 1'b0;
			facq_m_q <= 1'b1;
			facq_s_q <= 1'b1;
		end
		else
		begin
			gate_m_q <= read_gate;
			gate_s_q <= gate_m_q;
			facq_m_q <= freq_acq_n;
			facq_s_q <= facq_m_q;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			vco_q <= 1'b0;
			vco_prev_q <= 1'b0;
			ref_q <= 1'b0;
			data_prev_q <= 1'b0;
		end
		else
		begin
			vco_q <= vco_clk;
			vco_prev_q <= vco_q;
			ref_q <= ref_clk;
			data_prev_q <= raw_read_pulses;
		end
	end

	assign vco_rise = vco_q && !vco_prev_q;
	assign vco_fall = !vco_q && vco_prev_q;
	assign data_rise = raw_read_pulses && !data_prev_q;
	assign pre_target = (preamble_type_sel == RDSS_PRE_TYPE_4T) ? RDSS_PRE_CNT_LONG
		: RDSS_PRE_CNT_SHORT;

	// lock sequencing
	always_comb
	begin
		state_d = state_q;
		zps_cnt_d = zps_cnt_q;
		if (!gate_s_q)
		begin
			state_d = SEQ_IDLE;
			zps_cnt_d = 2'h0;
		end
		else
		begin
			unique case (state_q)
				SEQ_IDLE:
				begin
					state_d = SEQ_ZPS_WAIT;
					zps_cnt_d = 2'h0;
				end
				SEQ_ZPS_WAIT:
					if (vco_rise)
					begin
						zps_cnt_d = zps_cnt_q + 2'h1;
						if (zps_cnt_d == RDSS_ZPS_VCO_CYCLES)
						begin
							state_d = SEQ_PAUSE;
							zps_cnt_d = 2'h0;
						end
					end
				SEQ_PAUSE:
					if (data_rise)
					begin
						zps_cnt_d = zps_cnt_q + 2'h1;
						if (zps_cnt_d == RDSS_ZPS_DATA_PULSES)
							state_d = facq_s_q ? SEQ_PHASE : SEQ_FREQ;
					end
				SEQ_FREQ:
					if (facq_s_q)
						state_d = SEQ_PHASE;
				SEQ_PHASE:
					state_d = SEQ_PHASE;
				default:
					state_d = SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= SEQ_IDLE;
			zps_cnt_q <= 2'h0;
		end
		else
		begin
			state_q <= state_d;
			zps_cnt_q <= zps_cnt_d;
		end
	end

	// loop steering outputs
	assign coast = !freerun_hold_n || cfg_q[RDSS_CFG_COAST_BIT];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			vco_run <= 1'b1;
			zero_phase_restart <= 1'b0;
			freq_acq_active <= 1'b1;
			freq_target_sel <= 2'h0;
			window_gate_en <= 1'b0;
			pump_enable <= 1'b0;
			comparator_clear <= 1'b1;
			boost_resistor_en <= 1'b0;
		end
		else
		begin
			vco_run <= state_d != SEQ_PAUSE;
			zero_phase_restart <= state_q == SEQ_PAUSE && state_d != SEQ_PAUSE
				&& gate_s_q;
			freq_acq_active <= state_d == SEQ_IDLE || state_d == SEQ_FREQ;
			freq_target_sel <= preamble_type_sel;
			window_gate_en <= state_d == SEQ_PHASE;
			pump_enable <= !coast && state_d != SEQ_PAUSE;
			comparator_clear <= coast;
			boost_resistor_en <= !boost_gain_off;
		end
	end

	// preamble detection runs only after the restart
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !gate_s_q)
		begin
			pre_cnt_q <= 6'h00;
			preamble_found <= 1'b0;
		end
		else if ((state_q == SEQ_FREQ || state_q == SEQ_PHASE) && data_rise && !preamble_found)
		begin
			pre_cnt_q <= pre_cnt_q + 6'h01;
			if (pre_cnt_q + 6'h01 == pre_target)
				preamble_found <= 1'b1;
		end
	end

	// clock mux parks low between sources so no pulse is shortened
	assign want_vco = state_q == SEQ_FREQ || state_q == SEQ_PHASE;
	assign cur_src = src_vco_q ? vco_q : ref_q;
	assign new_src = want_vco ? vco_q : ref_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_vco_q <= 1'b0;
			dead_q <= 1'b0;
		end
		else if (!dead_q && want_vco != src_vco_q && !cur_src && !recovered_clock_out)
			dead_q <= 1'b1;
		else if (dead_q && !new_src)
		begin
			src_vco_q <= want_vco;
			dead_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			recovered_clock_out <= 1'b0;
		else
			recovered_clock_out <= dead_q ? 1'b0 : cur_src;
	end

	// data is released on the vco rising edge; a new pulse beats the clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			data_pend_q <= 1'b0;
			resynced_data <= 1'b0;
		end
		else
		begin
			if (data_rise)
				data_pend_q <= 1'b1;
			else if (vco_rise)
				data_pend_q <= 1'b0;
			if (vco_rise)
				resynced_data <= data_pend_q && src_vco_q;
		end
	end

	// oscillator sub-range: 0 is the slowest, 5 the fastest
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			vco_subrange <= 3'h0;
		else
			unique casez (rate_range_sel)
				3'b11?: vco_subrange <= 3'h0;
				3'b101: vco_subrange <= 3'h1;
				3'b100: vco_subrange <= 3'h2;
				3'b011: vco_subrange <= 3'h3;
				3'b010: vco_subrange <= 3'h4;
				3'b00?: vco_subrange <= 3'h5;
			endcase
	end

	// strobe: direction bit picks early or late, magnitude counts steps
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			strobe_word <= RDSS_STROBE_RST;
			strobe_steps <= 5'sh00;
		end
		else
		begin
			strobe_word <= strobe_q;
			strobe_steps <= strobe_q[RDSS_STROBE_DIR_BIT] ? $signed({1'b0, strobe_q[3:0]})
				: -$signed({1'b0, strobe_q[3:0]});
		end
	end

	rdss_ctrl_shift u_shift
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.shift_clock(ctrl_shift_clock),
		.shift_data(ctrl_shift_data),
		.shift_enable(ctrl_shift_enable),
		.word_q(ser_word),
		.apply_q(ser_apply)
	);

	rdss_phase_cmp u_pcmp
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.vco_level(vco_q),
		.vco_fall(vco_fall),
		.data_rise(data_rise),
		.clear(coast || state_q == SEQ_PAUSE),
		.raise_q(phase_raise_ind),
		.lower_q(phase_lower_ind)
	);

	// axi4-lite write side
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RDSS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid)
			begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q[7:2] == RDSS_REG_STROBE[7:2]
					|| awaddr_q[7:2] == RDSS_REG_CONFIG[7:2]
					|| awaddr_q[7:2] == RDSS_REG_STATUS[7:2]) ? RDSS_RESP_OKAY
					: RDSS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// serial load wins over a software write landing the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			strobe_q <= RDSS_STROBE_RST;
			cfg_q <= RDSS_CFG_RST;
		end
		else if (ser_apply)
			strobe_q <= ser_word;
		else if (aw_got_q && w_got_q && !s_axi_bvalid && wstrb_q[0])
		begin
			if (awaddr_q[7:2] == RDSS_REG_STROBE[7:2])
				strobe_q <= wdata_q[4:0];
			if (awaddr_q[7:2] == RDSS_REG_CONFIG[7:2])
				cfg_q <= wdata_q[RDSS_CFG_COAST_BIT +: 1];
		end
	end

	// axi4-lite read side
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RDSS_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RDSS_RESP_OKAY;
			s_axi_rdata <= 32'h0;
			unique case (s_axi_araddr[7:2])
				RDSS_REG_STROBE[7:2]: s_axi_rdata[4:0] <= strobe_q;
				RDSS_REG_CONFIG[7:2]: s_axi_rdata[0] <= cfg_q[0];
				RDSS_REG_STATUS[7:2]:
				begin
					s_axi_rdata[RDSS_ST_STATE_LSB +: 3] <= state_q;
					s_axi_rdata[RDSS_ST_FOUND_BIT] <= preamble_found;
					s_axi_rdata[RDSS_ST_SRC_BIT] <= src_vco_q;
					s_axi_rdata[RDSS_ST_STROBE_LSB +: 5] <= strobe_q;
					s_axi_rdata[RDSS_ST_SUBR_LSB +: 3] <= vco_subrange;
				end
				default: s_axi_rresp <= RDSS_RESP_SLVERR;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	chk_idle_acquires: assert property (state_q == SEQ_IDLE && !gate_s_q |=> freq_acq_active)
		else $error("idle loop not in frequency acquisition");
	chk_zps_pause: assert property (state_q == SEQ_ZPS_WAIT && gate_s_q && vco_rise
		&& zps_cnt_q == 2'h1 |=> state_q == SEQ_PAUSE ##0 !vco_run)
		else $error("oscillator not paused after two cycles");
	chk_freq_unwindowed: assert property (state_q == SEQ_FREQ |-> !window_gate_en)
		else $error("window gate active during acquisition");
	chk_freq_holds: assert property (state_q == SEQ_FREQ && gate_s_q && !facq_s_q
		|=> state_q == SEQ_FREQ)
		else $error("left acquisition with freq_acq_n low");
	chk_found_sticky: assert property (preamble_found && gate_s_q |=> preamble_found)
		else $error("preamble flag dropped while gate high");
	chk_gain_select: assert property (boost_gain_off |=> !boost_resistor_en)
		else $error("boost resistor used while disabled");
	// the switch back waits for both sources to sit low, up to a dozen cycles
	chk_idle_ref_src: assert property (state_q == SEQ_IDLE [*8] ##1 state_q == SEQ_IDLE [*8]
		|-> !src_vco_q)
		else $error("oscillator selected while idle");
	chk_mux_parked: assert property (dead_q |=> !recovered_clock_out)
		else $error("clock output high during source switch");
	chk_hold_clears: assert property (!freerun_hold_n |=> !pump_enable && comparator_clear)
		else $error("pump active during free run hold");
	chk_top_range: assert property (rate_range_sel[2:1] == 2'b00 |=> vco_subrange == 3'h5)
		else $error("wrong sub-range for top codes");
	chk_serial_apply: assert property (ser_apply |=> strobe_q == $past(ser_word))
		else $error("serial word not applied");
	chk_gate_drop: assert property (!gate_s_q |=> state_q == SEQ_IDLE && !preamble_found)
		else $error("sequence not cleared by gate drop");

endmodule : rdss_top

// ==== test/rdss_disk_model.sv ====
// disk controller side model: reference clock, oscillator sample, preamble pulses
// assumes aclk runs throughout and the synchronizer drives vco_run and preamble_found
`timescale 1ns/100ps
module rdss_disk_model
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// from the synchronizer
	input wire logic vco_run,
	input wire logic zero_phase_restart,
	input wire logic preamble_found,
	// to the synchronizer
	output logic ref_clk,
	output logic vco_clk,
	output logic raw_read_pulses,
	output logic freq_acq_n
);
	logic [2:0] ref_cnt_q = 3'h0;
	logic [2:0] vco_cnt_q = 3'h0;
	logic [3:0] data_cnt_q = 4'h0;

	// reference keeps running through reset, the delay line always needs it
	always_ff @(posedge aclk)
	begin
		ref_cnt_q <= ref_cnt_q + 3'h1;
		ref_clk <= ref_cnt_q[2];
	end

	// oscillator output stops while paused and restarts in phase
	always_ff @(posedge aclk)
	begin
		if (!aresetn || zero_phase_restart)
			vco_cnt_q <= 3'h0;
		else if (vco_run)
			vco_cnt_q <= vco_cnt_q + 3'h1;
		// the restart cycle must not leak the count held during the pause as a stub pulse
		vco_clk <= vco_run && !zero_phase_restart && vco_cnt_q[2];
	end

	// plain two-period preamble, never group coded, so legal in every range
	always_ff @(posedge aclk)
	begin
		data_cnt_q <= data_cnt_q + 4'h1;
		raw_read_pulses <= data_cnt_q < 4'h2;
	end

	// found flag tied back for automatic switch to phase lock
	always_ff @(posedge aclk)
		freq_acq_n <= preamble_found;

endmodule : rdss_disk_model

// ==== test/tb.sv ====
// testbench: axi register access, serial strobe load and lock sequencing
// assumes the disk model supplies clocks, read pulses and freq_acq_n
`timescale 1ns/100ps
module tb
	import rdss_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, preamble_type_sel, freq_target_sel, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic read_gate, freq_acq_n, freerun_hold_n, boost_gain_off, ref_clk, vco_clk;
	logic raw_read_pulses, ctrl_shift_clock, ctrl_shift_data, ctrl_shift_enable;
	logic recovered_clock_out, resynced_data, preamble_found, phase_raise_ind, phase_lower_ind;
	logic vco_run, zero_phase_restart, freq_acq_active, window_gate_en, pump_enable;
	logic comparator_clear, boost_resistor_en;
	logic [2:0] rate_range_sel, vco_subrange;
	logic [4:0] strobe_word;
	logic signed [4:0] strobe_steps;
	logic [4:0] words [6] = '{5'h10, 5'h0f, 5'h1f, 5'h01, 5'h11, 5'h0a};
	logic [2:0] sub [8] = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
	int error_cnt = 0;
	int checked = 0;

	always #25 aclk = ~aclk;

	rdss_top i_rdss_top
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .read_gate, .freq_acq_n,
		.freerun_hold_n, .boost_gain_off, .preamble_type_sel, .rate_range_sel, .ref_clk,
		.vco_clk, .raw_read_pulses, .ctrl_shift_clock, .ctrl_shift_data, .ctrl_shift_enable,
		.recovered_clock_out, .resynced_data, .preamble_found, .phase_raise_ind,
		.phase_lower_ind, .vco_run, .zero_phase_restart, .freq_acq_active, .freq_target_sel,
		.window_gate_en, .pump_enable, .comparator_clear, .boost_resistor_en, .vco_subrange,
		.strobe_word, .strobe_steps
	);

	rdss_disk_model i_rdss_disk_model
	(
		.aclk, .aresetn, .vco_run, .zero_phase_restart, .preamble_found, .ref_clk,
		.vco_clk, .raw_read_pulses, .freq_acq_n
	);

	task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_val

	task automatic tally_and_finish();
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// a used-up bound ends the run at once
	task automatic hang(input int n, input int lim);
		cmp_val("wait bound", 1, n < lim);
		if (n >= lim)
			tally_and_finish();
	endtask : hang

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		hang(n, 40);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		hang(n, 40);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd

	// msb first, so the first bit ends up as the direction bit
	task automatic shift_word(input logic [4:0] w, input logic en);
		ctrl_shift_enable <= en;
		for (int i = 4; i >= 0; i--)
		begin
			ctrl_shift_data <= w[i];
			tick(2);
			ctrl_shift_clock <= 1'b1;
			tick(2);
			ctrl_shift_clock <= 1'b0;
		end
		tick(2);
		ctrl_shift_enable <= 1'b1;
		tick(5);
	endtask : shift_word

	task automatic lock_run(input logic [1:0] pt, input int exp);
		int n, cnt, seen, run, narrow, rises, sd;
		logic prev, paused, acq, rprev;
		cnt = -1;
		seen = 0;
		prev = 1'b1;
		paused = 1'b0;
		acq = 1'b0;
		run = 0;
		narrow = 0;
		rises = 0;
		sd = 0;
		rprev = 1'b1;
		preamble_type_sel <= pt;
		read_gate <= 1'b1;
		for (n = 0; n < 3000 && preamble_found !== 1'b1; n++)
		begin
			@(posedge aclk);
			// a high pulse on the clock output must last half a source period
			if (recovered_clock_out === 1'b1 && !rprev)
				run = 1;
			else if (recovered_clock_out === 1'b1 && run > 0)
				run++;
			else if (recovered_clock_out !== 1'b1 && rprev && run > 0 && run < 4)
				narrow++;
			rprev = recovered_clock_out === 1'b1;
			if (vco_run === 1'b0 && cnt < 0)
				paused = 1'b1;
			if (zero_phase_restart === 1'b1)
				cnt = 0;
			else if (cnt >= 0 && raw_read_pulses && !prev)
				cnt++;
			if (cnt == 4)
				acq = freq_acq_active && !window_gate_en && freq_target_sel === pt;
			prev = raw_read_pulses;
		end
		hang(n, 3000);
		cmp_val("narrow pulse", 0, narrow);
		cmp_val("paused", 1, paused);
		cmp_val("pulses", exp, cnt);
		cmp_val("acquire", 1, acq);
		tick(12);
		cmp_val("phase lock", 1, window_gate_en);
		axi_rd(RDSS_REG_STATUS);
		cmp_val("status", 32'h1c, rd[4:0]);
		rprev = recovered_clock_out === 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge aclk);
			if (phase_raise_ind === 1'b1 || phase_lower_ind === 1'b1)
				seen++;
			if (recovered_clock_out === 1'b1 && !rprev)
				rises++;
			rprev = recovered_clock_out === 1'b1;
			if (resynced_data === 1'b1)
				sd++;
		end
		cmp_val("indicators", 1, seen > 0);
		cmp_val("clock edges", 8, rises);
		cmp_val("sync data", 1, sd > 0);
		cmp_val("pump on", 1, pump_enable);
		freerun_hold_n <= 1'b0;
		tick(4);
		cmp_val("coast", 2, {pump_enable, comparator_clear, phase_raise_ind | phase_lower_ind});
		freerun_hold_n <= 1'b1;
		axi_wr(RDSS_REG_CONFIG, 32'h1);
		tick(2);
		cmp_val("soft coast", 0, pump_enable);
		axi_wr(RDSS_REG_CONFIG, 32'h0);
		cmp_val("found held", 1, preamble_found);
		read_gate <= 1'b0;
		for (n = 0; n < 8 && preamble_found !== 1'b0; n++)
			@(posedge aclk);
		hang(n, 8);
		tick(16);
		cmp_val("idle", 1, freq_acq_active);
		axi_rd(RDSS_REG_STATUS);
		cmp_val("status idle", 0, rd[4:0]);
	endtask : lock_run

	initial
	begin
		logic signed [4:0] st;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{read_gate, boost_gain_off, ctrl_shift_clock, ctrl_shift_data} = 4'h0;
		{freerun_hold_n, ctrl_shift_enable} = 2'h3;
		preamble_type_sel = 2'h0;
		rate_range_sel = 3'h0;
		tick(6);
		aresetn <= 1'b1;
		tick(1);
		cmp_val("reset state", 5, {vco_run, pump_enable, comparator_clear});
		cmp_val("idle acquire", 1, freq_acq_active);
		shift_word(5'h00, 1'b0);
		cmp_val("zero strobe", 0, strobe_steps);
		foreach (words[i])
		begin
			shift_word(words[i], 1'b0);
			st = words[i][4] ? $signed({1'b0, words[i][3:0]}) : -$signed({1'b0, words[i][3:0]});
			cmp_val("strobe word", words[i], strobe_word);
			cmp_val("strobe steps", st, strobe_steps);
		end
		shift_word(5'h15, 1'b1);
		cmp_val("enable high", 5'h0a, strobe_word);
		axi_wr(RDSS_REG_STROBE, 32'h13);
		cmp_val("wr resp", RDSS_RESP_OKAY, resp);
		tick(2);
		cmp_val("axi strobe", 5'h13, strobe_word);
		axi_rd(RDSS_REG_STROBE);
		cmp_val("rd strobe", 32'h13, rd);
		axi_wr(8'h0c, 32'h1f);
		cmp_val("unmapped wr", RDSS_RESP_SLVERR, resp);
		axi_rd(8'h10);
		cmp_val("unmapped rd", RDSS_RESP_SLVERR, resp);
		cmp_val("unmapped data", 0, rd);
		axi_wr(RDSS_REG_STROBE, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			rate_range_sel <= 3'(i);
			boost_gain_off <= i[0];
			tick(3);
			cmp_val("subrange", sub[i], vco_subrange);
			cmp_val("boost", !i[0], boost_resistor_en);
		end
		lock_run(2'h0, 32);
		lock_run(RDSS_PRE_TYPE_4T, 16);
		tally_and_finish();
	end

endmodule : tb
